/* acpr_consts.vh */
// Timing and width constants for the converter host controller.
`ifndef ACPR_CONSTS_VH
`define ACPR_CONSTS_VH
`define ACPR_CLK_PERIOD_PS   5000
`define ACPR_PWRUP_EXT_NS    1000
`define ACPR_PWRUP_INT_NS    25000
`define ACPR_ACQ_NS          30
`define ACPR_EOC_MAX_NS      110
`define ACPR_SAMPLE_MAX_NS   530
`define ACPR_RD_HOLD_CYC     4
`define ACPR_CNT_W           16
`define ACPR_DATA_W          8
`define ACPR_ADDR_W          3
`define ACPR_MODE_HS         1'b0
`define ACPR_MODE_APD        1'b1
`endif

/* acpr_host.v */
// Host controller that powers up, starts and reads a sampling 8-bit converter.
`timescale 1ns/100ps
`include "acpr_consts.vh"
// Summary of operation
// - Internal reference: no fall before 25 us.
// - High-speed: wait 30 ns after read before start.
// - Auto mode: hold convert_start low past end pulse.
// - Select may stay low; read alone controls access.
// - End pulse may drive select and read directly.
module acpr_host #(
	parameter INT_REF       = 1'b0,
	parameter HAS_PD        = 1'b1,
	parameter PWRUP_INT_CYC = ((`ACPR_PWRUP_INT_NS * 1000) + `ACPR_CLK_PERIOD_PS - 1)
		/ `ACPR_CLK_PERIOD_PS
) (
	// Clock, reset and enable.
	input  wire                     mclk_i,
	input  wire                     reset_n_i,
	input  wire                     clk_en_i,
	// User command side.
	input  wire                     start_i,
	input  wire                     auto_pd_i,
	input  wire                     shutdown_i,
	input  wire [`ACPR_ADDR_W-1:0]  chan_i,
	output wire                     ready_o,
	output reg                      valid_o,
	output reg  [`ACPR_DATA_W-1:0]  data_o,
	output reg                      powered_o,
	// Converter pins.
	output reg                      convert_start_n_o,
	output reg                      power_down_n_o,
	output reg                      device_select_n_o,
	output reg                      read_strobe_n_o,
	output reg  [`ACPR_ADDR_W-1:0]  addr_o,
	input  wire                     end_of_conversion_n_i,
	input  wire [`ACPR_DATA_W-1:0]  data_i
);
	localparam PWRUP_EXT_CYC = ((`ACPR_PWRUP_EXT_NS * 1000) + `ACPR_CLK_PERIOD_PS - 1)
		/ `ACPR_CLK_PERIOD_PS;
	localparam ACQ_CYC  = ((`ACPR_ACQ_NS * 1000) + `ACPR_CLK_PERIOD_PS - 1)
		/ `ACPR_CLK_PERIOD_PS;
	localparam SMP_CYC  = (`ACPR_SAMPLE_MAX_NS * 1000) / `ACPR_CLK_PERIOD_PS;
	localparam RD_CYC   = `ACPR_RD_HOLD_CYC;
	localparam [`ACPR_CNT_W-1:0] PWRUP_CYC = INT_REF ? PWRUP_INT_CYC[`ACPR_CNT_W-1:0]
		: PWRUP_EXT_CYC[`ACPR_CNT_W-1:0];
	localparam [`ACPR_CNT_W-1:0] ACQ_C = ACQ_CYC[`ACPR_CNT_W-1:0];
	localparam [`ACPR_CNT_W-1:0] SMP_C = SMP_CYC[`ACPR_CNT_W-1:0];
	localparam [`ACPR_CNT_W-1:0] RD_C  = RD_CYC[`ACPR_CNT_W-1:0];

	localparam [2:0] S_OFF   = 3'h0;
	localparam [2:0] S_PWRUP = 3'h1;
	localparam [2:0] S_IDLE  = 3'h2;
	localparam [2:0] S_CONV  = 3'h3;
	localparam [2:0] S_READ  = 3'h4;
	localparam [2:0] S_ACQ   = 3'h5;

	reg [2:0]              state_r;
	reg [`ACPR_CNT_W-1:0]  cnt_r;
	reg                    mode_r;
	reg                    eoc_s1_r;
	reg                    eoc_s2_r;
	reg [`ACPR_DATA_W-1:0] dat_s1_r;
	reg [`ACPR_DATA_W-1:0] dat_s2_r;
	genvar                 gi;

	assign ready_o = (state_r == S_IDLE) || (state_r == S_OFF);

	// Counter expiry is tested in several states, so it is decoded once here.
	function cnt_done;
		input [`ACPR_CNT_W-1:0] cnt;
		begin
			cnt_done = (cnt == {`ACPR_CNT_W{1'b0}});
		end
	endfunction

	// Pin inputs are asynchronous to mclk_i, so each passes two flip-flops.
	// The end pulse resets to its idle high level so that no false pulse
	// is seen when reset is released.
	always @(posedge mclk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			eoc_s1_r <= 1'b1;
			eoc_s2_r <= 1'b1;
		end else if (clk_en_i) begin
			eoc_s1_r <= end_of_conversion_n_i;
			eoc_s2_r <= eoc_s1_r;
		end
	end

	// Each data bit has its own pair of flip-flops. Bits may settle in
	// different cycles, which is harmless because the read strobe holds
	// the bus steady for longer than the synchroniser delay.
	generate
		for (gi = 0; gi < `ACPR_DATA_W; gi = gi + 1) begin : g_dat_sync
			always @(posedge mclk_i or negedge reset_n_i) begin
				if (!reset_n_i) begin
					dat_s1_r[gi] <= 1'b0;
					dat_s2_r[gi] <= 1'b0;
				end else if (clk_en_i) begin
					dat_s1_r[gi] <= data_i[gi];
					dat_s2_r[gi] <= dat_s1_r[gi];
				end
			end
		end
	endgenerate

	// While clk_en_i is low every register below holds, so the pins freeze
	// too; a frozen read simply stretches the strobes.

	// The device starts powered down, so the host must power it up first.
	always @(posedge mclk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			state_r           <= S_OFF;
			cnt_r             <= {`ACPR_CNT_W{1'b0}};
			mode_r            <= `ACPR_MODE_HS;
			convert_start_n_o <= 1'b0;
			power_down_n_o    <= 1'b0;
			device_select_n_o <= 1'b1;
			read_strobe_n_o   <= 1'b1;
			addr_o            <= {`ACPR_ADDR_W{1'b0}};
			valid_o           <= 1'b0;
			data_o            <= {`ACPR_DATA_W{1'b0}};
			powered_o         <= 1'b0;
		end else if (clk_en_i) begin
			valid_o <= 1'b0;
			case (state_r)
			S_OFF: begin
				powered_o <= 1'b0;
				if (start_i) begin
					// A rising edge on either pin wakes the part; power_down_n
					// covers both the pin and the supply-on cases.
					convert_start_n_o <= 1'b1;
					power_down_n_o    <= 1'b1;
					cnt_r             <= PWRUP_CYC;
					state_r           <= S_PWRUP;
				end
			end
			S_PWRUP: begin
				// Waiting the full time also covers the internal reference limit.
				// The deferred start is never used, which costs at most one
				// power-up interval per wake but keeps both references alike.
				if (!cnt_done(cnt_r)) begin
					cnt_r <= cnt_r - 1'b1;
				end else begin
					powered_o <= 1'b1;
					state_r   <= S_IDLE;
				end
			end
			S_IDLE: begin
				// Without a power-down pin the part can only sleep through
				// auto mode, so a shutdown request is ignored then.
				if (shutdown_i && HAS_PD) begin
					power_down_n_o <= 1'b0;
					state_r        <= S_OFF;
				end else if (start_i) begin
					mode_r            <= auto_pd_i ? `ACPR_MODE_APD : `ACPR_MODE_HS;
					addr_o            <= chan_i;
					convert_start_n_o <= 1'b0;
					cnt_r             <= SMP_C;
					state_r           <= S_CONV;
				end
			end
			S_CONV: begin
				// High-speed mode raises the start pin before the end pulse.
				if (mode_r == `ACPR_MODE_HS)
					convert_start_n_o <= 1'b1;
				if (!cnt_done(cnt_r))
					cnt_r <= cnt_r - 1'b1;
				// The end pulse lasts at most 110 ns, so it is caught on
				// its falling level; the read then also cuts it short.
				if (!eoc_s2_r) begin
					device_select_n_o <= 1'b0;
					read_strobe_n_o   <= 1'b0;
					cnt_r             <= RD_C;
					state_r           <= S_READ;
				end
			end
			S_READ: begin
				// The strobes stay low long enough for the data to pass both
				// synchroniser stages before it is taken.
				if (!cnt_done(cnt_r)) begin
					cnt_r <= cnt_r - 1'b1;
				end else begin
					data_o            <= dat_s2_r;
					valid_o           <= 1'b1;
					device_select_n_o <= 1'b1;
					read_strobe_n_o   <= 1'b1;
					cnt_r             <= (mode_r == `ACPR_MODE_APD) ? SMP_C : ACQ_C;
					state_r           <= S_ACQ;
				end
			end
			S_ACQ: begin
				// In auto mode the start pin stays low past the end pulse.
				if (!cnt_done(cnt_r)) begin
					cnt_r <= cnt_r - 1'b1;
				end else if (mode_r == `ACPR_MODE_APD) begin
					powered_o <= 1'b0;
					state_r   <= S_OFF;
				end else begin
					state_r <= S_IDLE;
				end
			end
			default: state_r <= S_OFF;
			endcase
		end
	end
endmodule

/* acpr_dev_model.sv */
// Behavioural converter on the far side of the host controller.
`timescale 1ns/100ps
module acpr_dev_model (
	input  wire       convert_start_n_i,
	input  wire       power_down_n_i,
	input  wire       sel_n_i,
	input  wire       rd_n_i,
	input  wire [2:0] addr_i,
	output wire       end_of_conversion_n_o,
	output wire [7:0] data_o
);
	reg [7:0] res_r = 8'h5a;
	reg [2:0] chan_r = 3'h0;
	reg       eoc_r = 1'b1;
	reg       pwr_r = 1'b0;
	always @(posedge power_down_n_i or posedge convert_start_n_i) pwr_r = 1'b1;
	// The odd delay keeps the end pulse off the host's sampling edge.
	always @(negedge convert_start_n_i) if (pwr_r) begin
		#421 res_r = res_r + 8'h11;
		eoc_r = 1'b0;
		#100 eoc_r = 1'b1;
		if (!convert_start_n_i) pwr_r = 1'b0;
	end
	always @(negedge power_down_n_i) pwr_r = 1'b0;
	always @(posedge rd_n_i) eoc_r = 1'b1;
	always @(negedge rd_n_i) if (!sel_n_i) chan_r = addr_i;
	// A released bus shows inverted data, so a stale read cannot pass.
	assign data_o = (!sel_n_i && !rd_n_i) ? res_r ^ {5'h00, chan_r} : ~res_r;
	assign end_of_conversion_n_o = eoc_r;
endmodule

/* acpr_host_checker.sv */
// Concurrent checks on the host controller's converter pins.
`timescale 1ns/100ps
module acpr_host_checker (
	input wire mclk_i,
	input wire reset_n_i,
	input wire convert_start_n_o,
	input wire power_down_n_o,
	input wire device_select_n_o,
	input wire read_strobe_n_o,
	input wire end_of_conversion_n_i
);
	default clocking @(posedge mclk_i); endclocking
	default disable iff (!reset_n_i);
	sequence rd_low; (!read_strobe_n_o)[*5] ##1 read_strobe_n_o; endsequence
	a_wake_wait: assert property ($rose(power_down_n_o) |-> (!$fell(convert_start_n_o))[*8])
		else $error("early start");
	a_acq_gap: assert property ($rose(read_strobe_n_o) |-> (!$fell(convert_start_n_o))[*6])
		else $error("short acquire");
	a_apd_hold: assert property (!convert_start_n_o && !end_of_conversion_n_i |=> !convert_start_n_o)
		else $error("start released early");
	a_sel_read: assert property ($fell(read_strobe_n_o) |-> !device_select_n_o)
		else $error("read without select");
	a_rd_pulse: assert property ($fell(end_of_conversion_n_i) |-> ##[1:4] $fell(read_strobe_n_o) ##0 rd_low)
		else $error("read strobe");
endmodule
bind acpr_host acpr_host_checker chk (.mclk_i, .reset_n_i, .convert_start_n_o, .power_down_n_o,
	.device_select_n_o, .read_strobe_n_o, .end_of_conversion_n_i);

/* testbench.sv */
// Self-checking bench for the converter host controller.
`timescale 1ns/100ps
module testbench;
	reg             mclk_i = 1'b0;
	reg             reset_n_i = 1'b0;
	reg             start_i = 1'b0;
	reg             auto_pd_i = 1'b0;
	reg             shutdown_i = 1'b0;
	reg  [2:0]      chan_i = 3'h0;
	reg  [7:0]      exp_r = 8'h5a;
	logic [0:3][3:0] rows = 16'h0e7a;
	wire            valid_o, powered_o, conv_n, pd_n, sel_n, rd_n, eoc_n, ready;
	wire [2:0]      addr;
	wire [7:0]      data_o, bus;
	integer         miscompares = 0;
	integer         comparisons = 0;
	integer         i, n;
	acpr_host #(.PWRUP_INT_CYC(20)) DUT (.mclk_i, .reset_n_i, .clk_en_i(1'b1), .start_i,
		.auto_pd_i, .shutdown_i, .chan_i, .ready_o(ready), .valid_o, .data_o, .powered_o,
		.convert_start_n_o(conv_n), .power_down_n_o(pd_n), .device_select_n_o(sel_n),
		.read_strobe_n_o(rd_n), .addr_o(addr), .end_of_conversion_n_i(eoc_n), .data_i(bus));
	acpr_dev_model dev (.convert_start_n_i(conv_n), .power_down_n_i(pd_n), .sel_n_i(sel_n),
		.rd_n_i(rd_n), .addr_i(addr), .end_of_conversion_n_o(eoc_n), .data_o(bus));
	task check(input ok);
		begin
			comparisons = comparisons + 1;
			if (!ok) begin
				miscompares = miscompares + 1;
				$display("ERROR %0t pin or data mismatch", $time);
			end
		end
	endtask
	task conv(input [2:0] c, input a);
		begin
			exp_r = exp_r + 8'h11;
			@(posedge mclk_i);
			start_i <= 1'b1;
			chan_i <= c;
			auto_pd_i <= a;
			n = 0;
			while (!(powered_o === 1'b1 && conv_n === 1'b0) && n < 2000) begin
				@(negedge mclk_i);
				n = n + 1;
			end
			@(posedge mclk_i);
			start_i <= 1'b0;
			while (valid_o !== 1'b1 && n < 2000) begin
				@(negedge mclk_i);
				n = n + 1;
			end
			check(n < 2000);
			check(data_o === (exp_r ^ {5'h00, c}));
			repeat (200) @(negedge mclk_i);
			check(powered_o === !a && conv_n === !a && ready === 1'b1);
		end
	endtask
	task wrap_up;
		begin
			$display("comparisons %0d miscompares %0d", comparisons, miscompares);
			if (miscompares == 0 && comparisons > 0)
				$display("Result: passed");
			else
				$display("Result: failed");
			$finish;
		end
	endtask
	initial forever #2.5 mclk_i = ~mclk_i;
	initial begin
		#200000;
		miscompares = miscompares + 1;
		wrap_up;
	end
	initial begin
		repeat (4) @(posedge mclk_i);
		reset_n_i <= 1'b1;
		check(conv_n === 1'b0 && pd_n === 1'b0 && rd_n === 1'b1);
		for (i = 0; i < 4; i = i + 1)
			conv(rows[i][3:1], rows[i][0]);
		@(posedge mclk_i);
		shutdown_i <= 1'b1;
		@(posedge mclk_i);
		shutdown_i <= 1'b0;
		repeat (3) @(negedge mclk_i);
		check(pd_n === 1'b0 && powered_o === 1'b0);
		conv(3'h2, 1'b1);
		conv(3'h6, 1'b0);
		wrap_up;
	end
endmodule
